// >>> core/adcsf_defs.vh
// constants and register map for the converter status flag block
// What this block does
// - idle, calibration, new conversion set pending
// - pending set four modulator clocks before update
// - held result whose guard ends during host read is dropped
// - restart pin low sets pending if unread
// - error summary bit 6 mirrors any error
// - error summary copied to fifo status
// - error summary clears itself when errors gone
// - power-on flag set by por, read clears
// - reset: power-on 1, error 0, tag 0
// - tag bits 3:0 give stored result channel
// - tag follows stored result, not conversion
// - result store at guard end clears pending, result read sets
// - data-ready output follows pending flag
`ifndef ADCSF_DEFS_VH
`define ADCSF_DEFS_VH
`define ADCSF_ADDR_STATUS 4'h0
`define ADCSF_ADDR_CTRL 4'h4
`define ADCSF_ADDR_EVENTS 4'h8
`define ADCSF_ADDR_MASK 4'hC
`define ADCSF_BIT_PENDING 7
`define ADCSF_BIT_ERROR 6
`define ADCSF_BIT_POR 4
`define ADCSF_STATUS_RESET 8'h10
`define ADCSF_GUARD_MCLK 4'h4
`define ADCSF_RESP_OKAY 2'h0
`define ADCSF_RESP_SLVERR 2'h2
`endif

// >>> core/adcsf_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module adcsf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire reset,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  genvar i;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // a change counts only when second and third stages agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          level_out[i] <= INIT[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> core/adcsf_top.v
// converter status flag logic with axi4-lite register access
`timescale 1ns/10ps
`include "adcsf_defs.vh"
module adcsf_top (
  input wire sys_clk,
  input wire reset,
  input wire mclk_pin,
  input wire restart_n_pin,
  input wire por_event,
  input wire enter_idle,
  input wire cal_start,
  input wire conv_start,
  input wire result_write,
  input wire [3:0] result_channel,
  input wire coef_write,
  input wire result_read_busy,
  input wire result_read_done,
  input wire [7:0] error_flags,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg data_ready_n,
  output reg fifo_error_summary,
  output reg result_commit,
  output reg irq
);
  wire mclk_lvl;
  wire restart_n_lvl;
  reg mclk_d_reg;
  reg restart_d_reg;
  reg result_pending_n_reg;
  reg error_summary_reg;
  reg por_flag_reg;
  reg [3:0] result_channel_tag_reg;
  reg result_unread_reg;
  reg [3:0] guard_cnt_reg;
  reg [3:0] held_chan_reg;
  reg held_reg;
  reg guard_on_reg;
  reg [3:0] guard_len_reg;
  reg [2:0] events_reg;
  reg [2:0] mask_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [7:0] status_view;
  reg [2:0] ev_set;
  wire mclk_rise;
  wire restart_fall;
  wire guard_done;
  wire wr_fire;
  wire rd_fire;
  wire status_rd;
  wire commit_now;

  adcsf_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({mclk_pin, restart_n_pin}),
    .level_out({mclk_lvl, restart_n_lvl})
  );

  assign mclk_rise = mclk_lvl & ~mclk_d_reg;
  assign restart_fall = ~restart_n_lvl & restart_d_reg;
  assign guard_done = held_reg && guard_cnt_reg == 4'h0;
  // a host read still running when the guard ends costs this result
  assign commit_now = guard_done && !result_read_busy;
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status_rd = rd_fire && s_axi_araddr == `ADCSF_ADDR_STATUS;

  always @* begin
    status_view = 8'h00;
    status_view[`ADCSF_BIT_PENDING] = result_pending_n_reg;
    status_view[`ADCSF_BIT_ERROR] = error_summary_reg;
    status_view[`ADCSF_BIT_POR] = por_flag_reg;
    status_view[3:0] = result_channel_tag_reg;
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mclk_d_reg <= 1'b1;
      restart_d_reg <= 1'b1;
    end else begin
      mclk_d_reg <= mclk_lvl;
      restart_d_reg <= restart_n_lvl;
    end
  end

  // result pipeline: a result is held for the guard window in mclk cycles
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      held_reg <= 1'b0;
      held_chan_reg <= 4'h0;
      guard_cnt_reg <= 4'h0;
      result_commit <= 1'b0;
    end else begin
      result_commit <= 1'b0;
      if (result_write && !held_reg) begin
        held_reg <= 1'b1;
        held_chan_reg <= result_channel;
        guard_cnt_reg <= guard_len_reg;
      end else if (held_reg && guard_cnt_reg != 4'h0 && mclk_rise) begin
        guard_cnt_reg <= guard_cnt_reg - 4'h1;
      end else if (guard_done) begin
        held_reg <= 1'b0;
        result_commit <= !result_read_busy;
      end
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_pending_n_reg <= 1'b1;
    end else begin
      if (commit_now || coef_write) begin
        result_pending_n_reg <= 1'b0;
      end else if (enter_idle || cal_start || conv_start) begin
        result_pending_n_reg <= 1'b1;
      end else if (result_write && guard_on_reg) begin
        result_pending_n_reg <= 1'b1;
      end else if (result_read_done) begin
        result_pending_n_reg <= 1'b1;
      end else if (restart_fall && result_unread_reg) begin
        result_pending_n_reg <= 1'b1;
      end
    end
  end

  // channel tag and unread mark follow the stored result only
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_channel_tag_reg <= 4'h0;
      result_unread_reg <= 1'b0;
    end else if (commit_now) begin
      result_channel_tag_reg <= held_chan_reg;
      result_unread_reg <= 1'b1;
    end else if (result_read_done) begin
      result_unread_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      error_summary_reg <= 1'b0;
    end else begin
      error_summary_reg <= |error_flags;
    end
  end

  // fifo status copy sits beside the summary, never behind it
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fifo_error_summary <= 1'b0;
    end else begin
      fifo_error_summary <= |error_flags;
    end
  end

  // pin copy of the pending flag, one cycle behind it
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_ready_n <= 1'b1;
    end else begin
      data_ready_n <= result_pending_n_reg;
    end
  end

  // clear-on-read uses the value already latched into rdata
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      por_flag_reg <= 1'b1;
    end else if (por_event) begin
      por_flag_reg <= 1'b1;
    end else if (status_rd) begin
      por_flag_reg <= 1'b0;
    end
  end

  always @* begin
    ev_set = 3'h0;
    ev_set[0] = commit_now;
    ev_set[1] = |error_flags & ~error_summary_reg;
    ev_set[2] = por_event;
  end

  // axi write channel, either order of address and data
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  // write response; a status write is taken and ignored
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCSF_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `ADCSF_ADDR_STATUS) begin
          s_axi_bresp <= `ADCSF_RESP_OKAY;
        end else if (aw_addr_reg == `ADCSF_ADDR_CTRL) begin
          s_axi_bresp <= `ADCSF_RESP_OKAY;
        end else if (aw_addr_reg == `ADCSF_ADDR_EVENTS) begin
          s_axi_bresp <= `ADCSF_RESP_OKAY;
        end else if (aw_addr_reg == `ADCSF_ADDR_MASK) begin
          s_axi_bresp <= `ADCSF_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ADCSF_RESP_SLVERR;
        end
      end
    end
  end

  // guard control; a length of 0 stores a held result at once
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      guard_on_reg <= 1'b1;
      guard_len_reg <= `ADCSF_GUARD_MCLK;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == `ADCSF_ADDR_CTRL) begin
        guard_on_reg <= w_data_reg[0];
        guard_len_reg <= w_data_reg[7:4];
      end
    end
  end

  // a new event in the same cycle wins over the clear
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      events_reg <= 3'h0;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == `ADCSF_ADDR_EVENTS) begin
        events_reg <= (events_reg & ~w_data_reg[2:0]) | ev_set;
      end else begin
        events_reg <= events_reg | ev_set;
      end
    end else begin
      events_reg <= events_reg | ev_set;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_reg <= 3'h0;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == `ADCSF_ADDR_MASK) begin
        mask_reg <= w_data_reg[2:0];
      end
    end
  end

  // axi read channel; a new address waits until rvalid is taken
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // status is captured here before the power-on flag clears
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ADCSF_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rresp <= `ADCSF_RESP_OKAY;
      if (s_axi_araddr == `ADCSF_ADDR_STATUS) begin
        s_axi_rdata <= {24'h000000, status_view};
      end else if (s_axi_araddr == `ADCSF_ADDR_CTRL) begin
        s_axi_rdata <= {24'h000000, guard_len_reg, 3'h0, guard_on_reg};
      end else if (s_axi_araddr == `ADCSF_ADDR_EVENTS) begin
        s_axi_rdata <= {29'h00000000, events_reg};
      end else if (s_axi_araddr == `ADCSF_ADDR_MASK) begin
        s_axi_rdata <= {29'h00000000, mask_reg};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `ADCSF_RESP_SLVERR;
      end
    end
  end

  // level interrupt from any unmasked sticky event
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(events_reg & mask_reg);
    end
  end
endmodule

// >>> verification/adcsf_props.sv
// timing checks on the status flag outputs and bus holds
`timescale 1ns/10ps
module adcsf_props (
  input wire sys_clk,
  input wire reset,
  input wire enter_idle,
  input wire cal_start,
  input wire conv_start,
  input wire coef_write,
  input wire result_read_busy,
  input wire result_read_done,
  input wire [7:0] error_flags,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire data_ready_n,
  input wire fifo_error_summary,
  input wire result_commit
);
  wire set_ev = enter_idle | cal_start | conv_start;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_release;
    data_ready_n ##[1:2] !data_ready_n;
  endsequence
  sequence s_busy;
    result_read_busy [*2];
  endsequence
  AST_SET_PEND: assert property (set_ev |-> ##[1:3] data_ready_n)
    else $error("pending not set by event");
  AST_GUARD: assert property (result_commit |-> s_release)
    else $error("result stored without guard");
  AST_DROP: assert property (s_busy |-> !result_commit)
    else $error("result stored during host read");
  AST_ERR: assert property (fifo_error_summary == |$past(error_flags))
    else $error("error summary wrong");
  AST_COEF: assert property (coef_write && !set_ev |-> ##[1:3] !data_ready_n)
    else $error("coefficient write kept pending");
  AST_RDONE: assert property (result_read_done |-> ##[1:3] data_ready_n)
    else $error("result read did not set pending");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
endmodule
bind adcsf_top adcsf_props chk (
  .sys_clk(sys_clk), .reset(reset), .enter_idle(enter_idle),
  .cal_start(cal_start), .conv_start(conv_start), .coef_write(coef_write),
  .result_read_busy(result_read_busy),
  .result_read_done(result_read_done), .error_flags(error_flags),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .data_ready_n(data_ready_n), .fifo_error_summary(fifo_error_summary),
  .result_commit(result_commit)
);

// >>> verification/adcsf_mclk_model.sv
// free running modulator clock source beside the block
`timescale 1ns/10ps
module adcsf_mclk_model (
  output logic mclk_pin
);
  initial mclk_pin = 1'b0;
  // odd half period keeps it out of phase with sys_clk
  always #10.3 mclk_pin = ~mclk_pin;
endmodule

// >>> verification/adc_status_flag_logic_tb.sv
// self-checking bench for the converter status flag block
`timescale 1ns/10ps
module adc_status_flag_logic_tb;
  logic sys_clk = 0, reset = 1, restart_n_pin = 1, por_event = 0;
  logic result_write = 0, coef_write = 0, result_read_busy = 0;
  logic result_read_done = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [3:0] result_channel = 0, ch;
  logic [31:0] s_axi_wdata = 0;
  logic [33:0] q[$];
  logic [7:0] error_flags = 0;
  logic [2:0] sev = 0;
  wire enter_idle = sev[0], cal_start = sev[1], conv_start = sev[2];
  wire mclk_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
  wire s_axi_arready, s_axi_rvalid, data_ready_n, result_commit;
  wire fifo_error_summary;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer bad_count = 0, n_compared = 0, seed = 85, i, k;
  always #2.5 sys_clk = ~sys_clk;
  adcsf_top dut (.*);
  adcsf_mclk_model mdl (.mclk_pin(mclk_pin));
  task tally_and_finish;
    begin
      $display("mismatches %0d compared %0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk_rd(input [33:0] got, input [33:0] exp);
    begin
      n_compared++;
      if (got !== exp) begin
        bad_count++;
        $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input logic got, input logic exp);
    begin
      n_compared++;
      if (got !== exp) begin
        bad_count++;
        $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // read data is judged here, against the oldest note
  always @(posedge sys_clk)
    if (s_axi_rvalid && s_axi_rready)
      chk_rd({s_axi_rresp, s_axi_rdata}, q.pop_front());
  task rd(input [3:0] a, input [31:0] e);
    integer n;
    begin
      @(posedge sys_clk);
      q.push_back({(a[1:0] == 2'h0) ? 2'h0 : 2'h2, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (!s_axi_arready && n < 99);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid && n < 99) begin @(posedge sys_clk); n++; end
      s_axi_rready <= 1'b0;
      if (n >= 99) begin bad_count++; tally_and_finish; end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    integer n;
    logic ta, tw;
    begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ta = 0;
      tw = 0;
      n = 0;
      while (!(ta && tw) && n < 99) begin
        @(posedge sys_clk);
        n++;
        if (s_axi_awready) begin ta = 1; s_axi_awvalid <= 1'b0; end
        if (s_axi_wready) begin tw = 1; s_axi_wvalid <= 1'b0; end
      end
      while (!s_axi_bvalid && n < 99) begin @(posedge sys_clk); n++; end
      s_axi_bready <= 1'b0;
      if (n >= 99) begin bad_count++; tally_and_finish; end
      chk_rd(s_axi_bresp, (a[1:0] == 2'h0) ? 34'h0 : 34'h2);
    end
  endtask
  // a drop is only seen by waiting out the whole bound
  task wcm(input logic e);
    integer n;
    logic got;
    begin
      got = 0;
      for (n = 0; n < 200 && !got; n++) begin
        @(posedge sys_clk);
        if (result_commit) got = 1;
      end
      chk_pin(got, e);
    end
  endtask
  task pend_after(input integer c, input logic e);
    begin
      repeat (c) @(posedge sys_clk);
      chk_pin(data_ready_n, e);
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h0, 32'h00000090);
    rd(4'h0, 32'h00000080);
    rd(4'h4, 32'h00000041);
    rd(4'hC, 32'h00000000);
    chk_pin(irq, 1'b0);
    wr(4'h0, 8'hFF);
    rd(4'h0, 32'h00000080);
    por_event <= 1'b1;
    @(posedge sys_clk);
    por_event <= 1'b0;
    rd(4'h0, 32'h00000090);
    error_flags <= 8'($random(seed)) | 8'h01;
    repeat (3) @(posedge sys_clk);
    chk_pin(fifo_error_summary, 1'b1);
    for (i = 0; i < 16; i++) begin
      ch = i[3:0];
      result_channel <= ch;
      result_write <= 1'b1;
      @(posedge sys_clk);
      result_write <= 1'b0;
      wcm(1'b1);
      pend_after(2, 1'b0);
      rd(4'h0, {24'h000000, 4'h4, ch});
    end
    for (k = 0; k < 3; k++) begin
      coef_write <= 1'b1;
      @(posedge sys_clk);
      coef_write <= 1'b0;
      pend_after(3, 1'b0);
      sev <= 3'h1 << k;
      @(posedge sys_clk);
      sev <= 3'h0;
      pend_after(3, 1'b1);
    end
    rd(4'h0, 32'h000000CF);
    coef_write <= 1'b1;
    @(posedge sys_clk);
    coef_write <= 1'b0;
    restart_n_pin <= 1'b0;
    pend_after(12, 1'b1);
    restart_n_pin <= 1'b1;
    coef_write <= 1'b1;
    @(posedge sys_clk);
    coef_write <= 1'b0;
    result_read_done <= 1'b1;
    @(posedge sys_clk);
    result_read_done <= 1'b0;
    pend_after(3, 1'b1);
    result_read_busy <= 1'b1;
    result_channel <= 4'h3;
    result_write <= 1'b1;
    @(posedge sys_clk);
    result_write <= 1'b0;
    wcm(1'b0);
    result_read_busy <= 1'b0;
    rd(4'h0, 32'h000000CF);
    error_flags <= 8'h00;
    repeat (3) @(posedge sys_clk);
    chk_pin(fifo_error_summary, 1'b0);
    rd(4'h0, 32'h0000008F);
    wr(4'hC, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk_pin(irq, 1'b1);
    wr(4'h8, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk_pin(irq, 1'b0);
    rd(4'h8, 32'h00000006);
    rd(4'hC, 32'h00000001);
    wr(4'h6, 8'h00);
    rd(4'h6, 32'h00000000);
    tally_and_finish;
  end
  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end
endmodule
